// *** gio_defs.svh ***
// register offsets, field positions, reset values and vector bases of the port
`ifndef GIO_DEFS_SVH
`define GIO_DEFS_SVH
`define GIO_A_DIR 5'h00
`define GIO_A_DIRSET 5'h01
`define GIO_A_DIRCLR 5'h02
`define GIO_A_DIRTGL 5'h03
`define GIO_A_OUT 5'h04
`define GIO_A_OUTSET 5'h05
`define GIO_A_OUTCLR 5'h06
`define GIO_A_OUTTGL 5'h07
`define GIO_A_IN 5'h08
`define GIO_A_INTMASK0 5'h09
`define GIO_A_INTMASK1 5'h0A
`define GIO_A_INTFLAGS 5'h0B
`define GIO_A_MULTIMASK 5'h0C
`define GIO_A_MULTICFG 5'h0D
`define GIO_A_CTRL 5'h0E
`define GIO_A_EVSEL 5'h0F
`define GIO_A_VECBASE 5'h10
`define GIO_A_PINCFG0 5'h18
`define GIO_CTRL_SYNC 0
`define GIO_CTRL_ROUTE_LO 1
`define GIO_CTRL_REMAP 3
`define GIO_CTRL_RST 4'h1
`define GIO_OE_RST 8'hFF
`define GIO_ROUTE_NONE 2'h0
`define GIO_ROUTE_PCLK 2'h1
`define GIO_ROUTE_RTC 2'h2
`define GIO_ROUTE_EVENT 2'h3
`define GIO_SENSE_BOTH 2'h0
`define GIO_SENSE_RISE 2'h1
`define GIO_SENSE_FALL 2'h2
`define GIO_SENSE_LOW 2'h3
`define GIO_DRV_TOTEM 3'h0
`define GIO_DRV_TOTEM_PD 3'h1
`define GIO_DRV_TOTEM_PU 3'h2
`define GIO_DRV_KEEPER 3'h3
`define GIO_DRV_WOR 3'h4
`define GIO_DRV_WOR_PD 3'h5
`define GIO_DRV_WAND 3'h6
`define GIO_DRV_WAND_PU 3'h7
`define GIO_PORT_C 2'h0
`define GIO_PORT_R 2'h1
`define GIO_PORT_B 2'h2
`define GIO_VEC_C 8'h04
`define GIO_VEC_R 8'h08
`define GIO_VEC_B 8'h44
`endif

// *** gio_pkg.sv ***
// types shared by the port modules
package gio_pkg;
  typedef struct packed {
    logic inv;
    logic [2:0] drive;
    logic [1:0] sense;
  } gio_pcfg_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] outv;
    logic [7:0] m0;
    logic [7:0] m1;
    logic [7:0] flags;
    logic [7:0] multi;
    logic [3:0] ctrl;
    logic [1:0] evsel;
    gio_pcfg_t [7:0] pcfg;
    logic [7:0] rdata;
    logic [7:0] pin_out;
    logic [7:0] oe_n;
    logic [7:0] pu;
    logic [7:0] pd;
    logic [7:0] ev_out;
    logic irq0;
    logic irq1;
    logic wake;
    logic clk_div;
    logic [2:0] rtc_s;
    logic rtc_stab;
  } gio_top_t;
endpackage : gio_pkg

// *** gio_io_if.sv ***
// carrier between the core, the input synchroniser and the sense logic
interface gio_io_if;
  import gio_pkg::*;
  logic [7:0] s3;
  logic [7:0] stab;
  logic [7:0] hit;
  gio_pcfg_t [7:0] cfg;
  logic async_mode;
  modport sync_mp (output s3, output stab);
  modport sense_mp (input s3, input stab, input cfg, input async_mode,
    output hit);
  modport core_mp (input stab, input hit, output cfg, output async_mode);
endinterface : gio_io_if

// *** gio_sync.sv ***
// three-stage pin synchroniser with agreement filter
module gio_sync (
  input wire logic clock, // peripheral clock
  input wire logic rst_n, // synchronised reset
  input wire logic clk_en, // freezes state when low
  input wire logic [7:0] pin_in, // raw pin levels
  gio_io_if.sync_mp io // synchronised levels out
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] stab;
  } gio_sync_t;
  gio_sync_t st_ff;
  gio_sync_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.s1 = pin_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // a bit moves only once stages two and three agree
      nxt_st.stab = ((st_ff.s2 ^ st_ff.s3) & st_ff.stab) |
        (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign io.s3 = st_ff.s3;
  assign io.stab = st_ff.stab;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  stab_agree_a: assert property (
    clk_en && (st_ff.s2 != st_ff.s3) |=> st_ff.stab == $past(st_ff.stab))
    else $error("stable level moved without agreement");
endmodule : gio_sync

// *** gio_sense.sv ***
// per-pin edge and level detection on the possibly inverted level
`include "gio_defs.svh"

module gio_sense (
  input wire logic clock, // peripheral clock
  input wire logic rst_n, // synchronised reset
  input wire logic clk_en, // freezes state when low
  gio_io_if.sense_mp io // levels in, hits out
);
  import gio_pkg::*;
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] hit;
  } gio_sense_t;
  gio_sense_t st_ff;
  gio_sense_t nxt_st;
  logic [7:0] val;
  logic [7:0] hit_c;

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_pin
      // async mode takes the earlier stage: shorter path, no filter
      assign val[n] = (io.async_mode ? io.s3[n] : io.stab[n]) ^
        io.cfg[n].inv;
      always_comb begin
        case (io.cfg[n].sense)
          `GIO_SENSE_BOTH: hit_c[n] = val[n] ^ st_ff.prev[n];
          `GIO_SENSE_RISE: hit_c[n] = val[n] & ~st_ff.prev[n];
          `GIO_SENSE_FALL: hit_c[n] = ~val[n] & st_ff.prev[n];
          default: hit_c[n] = ~val[n];
        endcase
      end
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.prev = val;
      nxt_st.hit = hit_c;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign io.hit = st_ff.hit;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  rise_detect_a: assert property (
    clk_en && io.cfg[0].sense == `GIO_SENSE_RISE && val[0] &&
    !st_ff.prev[0] |=> io.hit[0])
    else $error("rising edge on pin 0 not detected");
  invert_sense_a: assert property (
    clk_en && !io.async_mode && io.cfg[1].sense == `GIO_SENSE_LOW &&
    io.cfg[1].inv |=> io.hit[1] == $past(io.stab[1]))
    else $error("inverted low level sense wrong on pin 1");
endmodule : gio_sense

// *** gio_port.sv ***
// eight-pin general purpose port: registers, drivers, sensing, interrupts
//
// The strobed register port and the address map were chosen for this implementation.
`include "gio_defs.svh"

// What this block does
// - eight pins, 0 to 7, each input or output with own driver, pulls.
// - per-pin sensing on both, rising, falling edge or low level.
// - two interrupt requests, each with its own per-pin mask.
// - asynchronous pin change sensing raises a wake request.
// - toggle, clear and set locations change only the written ones.
// - changing one pin's direction never alters another pin's.
// - one write configures every pin selected by a pin mask.
// - bus-keeper weakly holds the last level, pulling up or down.
// - inverted pins are inverted before input sensing.
// - sensing is synchronous with the CTRL sync bit set, else async.
// - enabled alternate functions override direction and output value.
// - driver is totem-pole, wired-AND, wired-OR or keeper, invertible.
// - optional pulls on inputs, wired-OR pull-down, wired-AND pull-up.
// - half the peripheral clock or the real-time clock can drive a pin.
// - a chosen event channel can drive a pin.
// - peripheral signals can move to an alternative pin set.
// - interrupt vector bases are 0x004, 0x008 and 0x044 per port.
module gio_port #(
  parameter logic [1:0] PORT_SEL = `GIO_PORT_C // which port this is
) (
  input wire logic clock, // 100 MHz peripheral clock
  input wire logic arst_n, // asynchronous reset
  input wire logic clk_en, // freezes all state but the reset synchroniser when low
  input wire logic [4:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after read strobe
  input wire logic [7:0] pin_in, // pin levels
  output logic [7:0] pin_out, // pin drive values
  output logic [7:0] pin_oe_n, // low while the pin is driven
  output logic [7:0] pull_up_en, // weak pull-up on
  output logic [7:0] pull_dn_en, // weak pull-down on
  input wire logic [7:0] alt_en, // peripheral owns the pin
  input wire logic [7:0] alt_dir, // peripheral direction
  input wire logic [7:0] alt_out, // peripheral output value
  input wire logic rtc_clk_in, // real-time counter clock
  input wire logic [3:0] ev_chan, // event system channels
  output logic [7:0] event_out, // sense hits, one cycle per edge, held while a low level lasts
  output logic irq0, // port interrupt request 0
  output logic irq1, // port interrupt request 1
  output logic wake // asynchronous pin change wake request
);
  import gio_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  //////////////////////////////////////////////////////////////////////////
  gio_io_if io ();
  gio_top_t st_ff;
  gio_top_t nxt_st;

  gio_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(pin_in),
    .io(io.sync_mp)
  );

  gio_sense u_sense (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .io(io.sense_mp)
  );

  assign io.cfg = st_ff.pcfg;
  assign io.async_mode = ~st_ff.ctrl[`GIO_CTRL_SYNC];

  //////////////////////////////////////////////////////////////////////////
  logic [7:0] a_en;
  logic [7:0] a_dir;
  logic [7:0] a_out;
  logic [7:0] o_src;
  logic [7:0] d_src;
  logic [7:0] drv;
  logic [7:0] v;
  logic [7:0] pu_c;
  logic [7:0] pd_c;
  logic route_bit;
  logic [7:0] vec_base;

  // remap swaps the peripheral's pin groups
  assign a_en = st_ff.ctrl[`GIO_CTRL_REMAP] ? {alt_en[3:0], alt_en[7:4]}
    : alt_en;
  assign a_dir = st_ff.ctrl[`GIO_CTRL_REMAP] ? {alt_dir[3:0], alt_dir[7:4]}
    : alt_dir;
  assign a_out = st_ff.ctrl[`GIO_CTRL_REMAP] ? {alt_out[3:0], alt_out[7:4]}
    : alt_out;

  always_comb begin
    case (st_ff.ctrl[`GIO_CTRL_ROUTE_LO +: 2])
      `GIO_ROUTE_PCLK: route_bit = st_ff.clk_div;
      `GIO_ROUTE_RTC: route_bit = st_ff.rtc_stab;
      `GIO_ROUTE_EVENT: route_bit = ev_chan[st_ff.evsel];
      default: route_bit = st_ff.outv[7];
    endcase
  end

  always_comb begin
    case (PORT_SEL)
      `GIO_PORT_R: vec_base = `GIO_VEC_R;
      `GIO_PORT_B: vec_base = `GIO_VEC_B;
      default: vec_base = `GIO_VEC_C;
    endcase
  end

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_pin
      // clock, rtc and event routes share pin 7 ahead of the out register
      if (n == 7) begin : g_route
        assign o_src[n] = a_en[n] ? a_out[n] : route_bit;
      end else begin : g_plain
        assign o_src[n] = a_en[n] ? a_out[n] : st_ff.outv[n];
      end
      assign d_src[n] = a_en[n] ? a_dir[n] : st_ff.dir[n];
      assign v[n] = o_src[n] ^ st_ff.pcfg[n].inv;
      always_comb begin
        drv[n] = d_src[n];
        pu_c[n] = 1'b0;
        pd_c[n] = 1'b0;
        case (st_ff.pcfg[n].drive)
          `GIO_DRV_TOTEM: drv[n] = d_src[n];
          `GIO_DRV_TOTEM_PD: pd_c[n] = ~d_src[n];
          `GIO_DRV_TOTEM_PU: pu_c[n] = ~d_src[n];
          `GIO_DRV_KEEPER: begin
            // keeper follows the last level seen on the pin
            pu_c[n] = ~d_src[n] & io.stab[n];
            pd_c[n] = ~d_src[n] & ~io.stab[n];
          end
          `GIO_DRV_WOR: drv[n] = d_src[n] & v[n];
          `GIO_DRV_WOR_PD: begin
            drv[n] = d_src[n] & v[n];
            pd_c[n] = ~(d_src[n] & v[n]);
          end
          `GIO_DRV_WAND: drv[n] = d_src[n] & ~v[n];
          `GIO_DRV_WAND_PU: begin
            drv[n] = d_src[n] & ~v[n];
            pu_c[n] = ~(d_src[n] & ~v[n]);
          end
          default: drv[n] = d_src[n];
        endcase
      end
      keeper_hold_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        clk_en && st_ff.pcfg[n].drive == `GIO_DRV_KEEPER && !d_src[n]
        |=> pull_up_en[n] == $past(io.stab[n]) &&
        pull_dn_en[n] == !$past(io.stab[n]) && pin_oe_n[n])
        else $error("bus keeper does not hold last level");
      wand_high_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        clk_en && st_ff.pcfg[n].drive[2:1] == 2'h3
        |=> !(!pin_oe_n[n] && pin_out[n]))
        else $error("wired-AND pin actively driven high");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  logic wr_hit;
  logic [7:0] cfg_sel;

  assign wr_hit = reg_wr && clk_en;

  always_comb begin
    // a single-pin location is a one-hot mask of the same write
    cfg_sel = 8'h00;
    if (reg_addr == `GIO_A_MULTICFG) begin
      cfg_sel = st_ff.multi;
    end else if (reg_addr[4:3] == `GIO_A_PINCFG0 >> 3) begin
      cfg_sel = 8'h01 << reg_addr[2:0];
    end
  end

  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.clk_div = ~st_ff.clk_div;
      nxt_st.rtc_s = {st_ff.rtc_s[1:0], rtc_clk_in};
      if (st_ff.rtc_s[1] == st_ff.rtc_s[2]) begin
        nxt_st.rtc_stab = st_ff.rtc_s[2];
      end
      // set wins over a write-one clear in the same cycle
      nxt_st.flags = st_ff.flags | io.hit;
      nxt_st.ev_out = io.hit;
      nxt_st.rdata = 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `GIO_A_DIR: nxt_st.rdata = st_ff.dir;
          `GIO_A_OUT: nxt_st.rdata = st_ff.outv;
          `GIO_A_IN: nxt_st.rdata = io.stab;
          `GIO_A_INTMASK0: nxt_st.rdata = st_ff.m0;
          `GIO_A_INTMASK1: nxt_st.rdata = st_ff.m1;
          `GIO_A_INTFLAGS: nxt_st.rdata = st_ff.flags;
          `GIO_A_MULTIMASK: nxt_st.rdata = st_ff.multi;
          `GIO_A_CTRL: nxt_st.rdata = {4'h0, st_ff.ctrl};
          `GIO_A_EVSEL: nxt_st.rdata = {6'h00, st_ff.evsel};
          `GIO_A_VECBASE: nxt_st.rdata = vec_base;
          default: begin
            if (reg_addr[4:3] == `GIO_A_PINCFG0 >> 3) begin
              nxt_st.rdata = {2'h0, st_ff.pcfg[reg_addr[2:0]]};
            end
          end
        endcase
      end
      if (reg_wr) begin
        case (reg_addr)
          `GIO_A_DIR: nxt_st.dir = reg_wdata;
          `GIO_A_DIRSET: nxt_st.dir = st_ff.dir | reg_wdata;
          `GIO_A_DIRCLR: nxt_st.dir = st_ff.dir & ~reg_wdata;
          `GIO_A_DIRTGL: nxt_st.dir = st_ff.dir ^ reg_wdata;
          `GIO_A_OUT: nxt_st.outv = reg_wdata;
          `GIO_A_OUTSET: nxt_st.outv = st_ff.outv | reg_wdata;
          `GIO_A_OUTCLR: nxt_st.outv = st_ff.outv & ~reg_wdata;
          `GIO_A_OUTTGL: nxt_st.outv = st_ff.outv ^ reg_wdata;
          `GIO_A_INTMASK0: nxt_st.m0 = reg_wdata;
          `GIO_A_INTMASK1: nxt_st.m1 = reg_wdata;
          `GIO_A_INTFLAGS: nxt_st.flags = (st_ff.flags & ~reg_wdata) |
            io.hit;
          `GIO_A_MULTIMASK: nxt_st.multi = reg_wdata;
          `GIO_A_CTRL: nxt_st.ctrl = reg_wdata[3:0];
          `GIO_A_EVSEL: nxt_st.evsel = reg_wdata[1:0];
          default: begin
            for (int k = 0; k < 8; k++) begin
              if (cfg_sel[k]) begin
                nxt_st.pcfg[k] = reg_wdata[5:0];
              end
            end
          end
        endcase
      end
      nxt_st.pin_out = v;
      nxt_st.oe_n = ~drv;
      nxt_st.pu = pu_c;
      nxt_st.pd = pd_c;
      nxt_st.irq0 = |(st_ff.flags & st_ff.m0);
      nxt_st.irq1 = |(st_ff.flags & st_ff.m1);
      // registered wake: no filter, reported while sensing is async
      nxt_st.wake = io.async_mode & |io.hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.oe_n <= `GIO_OE_RST;
      st_ff.ctrl <= `GIO_CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign pin_out = st_ff.pin_out;
  assign pin_oe_n = st_ff.oe_n;
  assign pull_up_en = st_ff.pu;
  assign pull_dn_en = st_ff.pd;
  assign event_out = st_ff.ev_out;
  assign irq0 = st_ff.irq0;
  assign irq1 = st_ff.irq1;
  assign wake = st_ff.wake;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  dir_set_a: assert property (
    wr_hit && reg_addr == `GIO_A_DIRSET
    |=> st_ff.dir == ($past(st_ff.dir) | $past(reg_wdata)))
    else $error("direction set location wrong");
  dir_clear_a: assert property (
    wr_hit && reg_addr == `GIO_A_DIRCLR
    |=> (st_ff.dir & ~$past(reg_wdata)) ==
    ($past(st_ff.dir) & ~$past(reg_wdata)) &&
    (st_ff.dir & $past(reg_wdata)) == 8'h00)
    else $error("direction clear touched other pins");
  out_toggle_a: assert property (
    wr_hit && reg_addr == `GIO_A_OUTTGL
    |=> st_ff.outv == ($past(st_ff.outv) ^ $past(reg_wdata)))
    else $error("output toggle location wrong");
  multi_cfg_a: assert property (
    wr_hit && reg_addr == `GIO_A_MULTICFG && st_ff.multi[2]
    |=> st_ff.pcfg[2] == $past(reg_wdata[5:0]))
    else $error("masked pin not configured");
  flag_sticky_a: assert property (
    clk_en && io.hit[3] |=> st_ff.flags[3] ##1 st_ff.flags[3] || !clk_en ||
    $past(reg_wr && reg_addr == `GIO_A_INTFLAGS && reg_wdata[3]))
    else $error("interrupt flag lost");
  irq_mask_a: assert property (
    clk_en && io.hit[4] && st_ff.m1[4] ##1 clk_en && st_ff.m1[4]
    |=> irq1)
    else $error("unmasked flag did not raise request 1");
  read_dir_a: assert property (
    clk_en && reg_rd && reg_addr == `GIO_A_DIR
    |=> reg_rdata == $past(st_ff.dir))
    else $error("direction read data wrong");
  alt_override_a: assert property (
    clk_en && a_en[0] && st_ff.pcfg[0].drive == `GIO_DRV_TOTEM
    |=> pin_oe_n[0] == !$past(a_dir[0]))
    else $error("alternate function did not own direction");

  flag_set_c: cover property (clk_en && io.hit != 8'h00);
  irq0_c: cover property (!irq0 ##1 irq0);
  multi_c: cover property (wr_hit && reg_addr == `GIO_A_MULTICFG &&
    st_ff.multi == 8'hFF);
  wake_c: cover property (wake);
endmodule : gio_port

// *** gio_pin_model.sv ***
// external circuitry on the eight port pins: drivers, pulls, floating lines
module gio_pin_model (
  input wire logic [7:0] pin_out, // device drive value
  input wire logic [7:0] pin_oe_n, // low while the device drives
  input wire logic [7:0] pull_up_en, // device weak pull-up
  input wire logic [7:0] pull_dn_en, // device weak pull-down
  input wire logic [7:0] ext_en, // outside driver on
  input wire logic [7:0] ext_val, // outside driver level
  output logic [7:0] pin_level // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held;
  ////////////////////////////////////////////////////////////////////////////
  // remember the last driven level so a released line can drift away from it
  always @(pin_out, pin_oe_n, ext_en, ext_val) begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) held[i] = pin_out[i];
      else if (ext_en[i]) held[i] = ext_val[i];
    end
  end
  always @* begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pull_up_en[i]) pin_level[i] = 1'b1;
      else if (pull_dn_en[i]) pin_level[i] = 1'b0;
      // no pull: never let a stale level pass for a held one
      else pin_level[i] = ~held[i];
    end
  end
endmodule : gio_pin_model

// *** test_general_purpose_io_port.sv ***
// self-checking bench for the eight-pin port
`include "gio_defs.svh"
`define CHK(n, e, g) check(n, e, g);
module test_general_purpose_io_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, clk_en, reg_wr, reg_rd, rtc_clk_in, irq0, irq1, wake;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, pull_up_en;
  logic [7:0] pull_dn_en, alt_en, alt_dir, alt_out, event_out, ext_en;
  logic [7:0] ext_val, rv;
  logic [3:0] ev_chan;
  logic p1;
  int miscompares, tests_run, evs, wakes;
  gio_port u_gio_port (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .alt_en(alt_en), .alt_dir(alt_dir),
    .alt_out(alt_out), .rtc_clk_in(rtc_clk_in), .ev_chan(ev_chan),
    .event_out(event_out), .irq0(irq0), .irq1(irq1), .wake(wake));
  gio_pin_model u_gio_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_level(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (event_out[0]) evs++;
    if (wake) wakes++;
  end
  task automatic check(input string n, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string n, input logic [4:0] a,
    input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(n, e, reg_rdata);
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    miscompares++;
    end_of_test;
  end
  initial begin
    clock = 0; arst_n = 0; clk_en = 1; reg_wr = 0; reg_rd = 0;
    reg_addr = 5'h00; reg_wdata = 8'h00; rtc_clk_in = 0; ev_chan = 4'h0;
    alt_en = 8'h00; alt_dir = 8'h00; alt_out = 8'h00;
    ext_en = 8'hFF; ext_val = 8'h00; evs = 0; wakes = 0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    cyc(3);
    rchk("dir_rst", `GIO_A_DIR, 8'h00);
    rchk("ctrl_rst", `GIO_A_CTRL, `GIO_CTRL_RST);
    rchk("vecbase", `GIO_A_VECBASE, `GIO_VEC_C);
    rchk("unmapped", 5'h11, 8'h00);
    `CHK("oe_rst", `GIO_OE_RST, pin_oe_n)
    $display("test reset done");
    wr(`GIO_A_DIRSET, 8'h05);
    wr(`GIO_A_DIRCLR, 8'h01);
    rchk("dirclr", `GIO_A_DIR, 8'h04);
    wr(`GIO_A_DIRTGL, 8'h03);
    rchk("dirtgl", `GIO_A_DIR, 8'h07);
    `CHK("oe_dir", 8'hF8, pin_oe_n)
    wr(`GIO_A_OUTSET, 8'hF0);
    wr(`GIO_A_OUTCLR, 8'h30);
    wr(`GIO_A_OUTTGL, 8'h0F);
    rchk("out_rmw", `GIO_A_OUT, 8'hCF);
    `CHK("pin_drive", 8'h07, pin_out & 8'h07)
    clk_en <= 1'b0;
    wr(`GIO_A_DIR, 8'hFF);
    clk_en <= 1'b1;
    rchk("frozen_wr", `GIO_A_DIR, 8'h07);
    wr(`GIO_A_DIR, 8'h00);
    $display("test rmw done");
    wr(`GIO_A_MULTIMASK, 8'h0C);
    wr(`GIO_A_MULTICFG, 8'h2A);
    rchk("multi2", `GIO_A_PINCFG0 + 5'h02, 8'h2A);
    rchk("multi3", `GIO_A_PINCFG0 + 5'h03, 8'h2A);
    rchk("multi1", `GIO_A_PINCFG0 + 5'h01, 8'h00);
    for (int d = 1; d < 8; d += 2) begin
      wr(`GIO_A_PINCFG0 + 5'h03, 8'(d << 2));
      cyc(2);
      rv = {6'h0, pull_up_en[3], pull_dn_en[3]};
      `CHK("pulls", {6'h0, d == 7, d < 7}, rv)
    end
    // keeper follows the synchronised level, so let it settle first
    wr(`GIO_A_PINCFG0 + 5'h03, {3'h0, `GIO_DRV_KEEPER, 2'h0});
    ext_val[3] <= 1'b1;
    cyc(8);
    `CHK("keep_hi", 8'h02, {6'h0, pull_up_en[3], pull_dn_en[3]})
    ext_val[3] <= 1'b0;
    cyc(8);
    `CHK("keep_lo", 8'h01, {6'h0, pull_up_en[3], pull_dn_en[3]})
    $display("test config done");
    wr(`GIO_A_PINCFG0, 8'h01);
    wr(`GIO_A_INTMASK0, 8'h01);
    wr(`GIO_A_INTFLAGS, 8'hFF);
    evs = 0;
    ext_val[0] <= 1'b1;
    cyc(10);
    rchk("flag_rise", `GIO_A_INTFLAGS, 8'h01);
    `CHK("irq0_on", 8'h01, {7'h0, irq0})
    `CHK("irq1_mask", 8'h00, {7'h0, irq1})
    `CHK("event", 8'h01, 8'(evs))
    wr(`GIO_A_INTMASK1, 8'h11);
    cyc(2);
    `CHK("irq1_on", 8'h01, {7'h0, irq1})
    wr(`GIO_A_INTFLAGS, 8'h01);
    cyc(2);
    `CHK("irq0_off", 8'h00, {7'h0, irq0})
    wr(`GIO_A_PINCFG0 + 5'h01, 8'h22);
    cyc(8);
    wr(`GIO_A_INTFLAGS, 8'hFF);
    ext_val[1] <= 1'b1;
    cyc(10);
    rchk("inv_fall", `GIO_A_INTFLAGS, 8'h02);
    // high pin seen inverted as low keeps hitting under low-level sense
    wr(`GIO_A_PINCFG0 + 5'h01, 8'h23);
    wr(`GIO_A_INTFLAGS, 8'hFF);
    rchk("inv_low", `GIO_A_INTFLAGS, 8'h02);
    wr(`GIO_A_PINCFG0 + 5'h01, 8'h22);
    wr(`GIO_A_PINCFG0 + 5'h04, 8'h03);
    wr(`GIO_A_INTFLAGS, 8'hFF);
    rchk("low_again", `GIO_A_INTFLAGS, 8'h10);
    ext_val[4] <= 1'b1;
    cyc(8);
    wr(`GIO_A_INTFLAGS, 8'hFF);
    rchk("low_gone", `GIO_A_INTFLAGS, 8'h00);
    $display("test sense done");
    wr(`GIO_A_CTRL, 8'h00);
    wr(`GIO_A_PINCFG0 + 5'h05, 8'h01);
    wakes = 0;
    ext_val[5] <= 1'b1;
    cyc(10);
    `CHK("wake", 8'h01, 8'(wakes))
    rchk("async_flag", `GIO_A_INTFLAGS, 8'h20);
    rchk("pin_in", `GIO_A_IN, 8'h33);
    $display("test async done");
    wr(`GIO_A_DIR, 8'h80);
    wr(`GIO_A_EVSEL, 8'h02);
    wr(`GIO_A_CTRL, 8'h07);
    ev_chan <= 4'h4;
    cyc(3);
    `CHK("ev_hi", 8'h80, pin_out & 8'h80)
    ev_chan <= 4'h0;
    cyc(3);
    `CHK("ev_lo", 8'h00, pin_out & 8'h80)
    wr(`GIO_A_CTRL, 8'h03);
    cyc(3);
    p1 = pin_out[7];
    cyc(1);
    `CHK("pclk", 8'h01, {7'h0, p1 ^ pin_out[7]})
    wr(`GIO_A_CTRL, 8'h05);
    rtc_clk_in <= 1'b1;
    cyc(6);
    `CHK("rtc", 8'h80, pin_out & 8'h80)
    wr(`GIO_A_CTRL, 8'h01);
    alt_en <= 8'h10;
    alt_dir <= 8'h10;
    alt_out <= 8'h10;
    cyc(3);
    `CHK("alt_pin", 8'h10, {pin_out[4], pin_oe_n[4]} << 3)
    wr(`GIO_A_CTRL, 8'h09);
    cyc(3);
    rv = {5'h0, pin_out[0], pin_oe_n[4], pin_oe_n[0]};
    `CHK("remap", 8'h06, rv)
    $display("test pin functions done");
    end_of_test;
  end
endmodule : test_general_purpose_io_port
